// File: common/pscr_defines.vh
`ifndef PSCR_DEFINES_VH
`define PSCR_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PSCR_IDX_W 6
`define PSCR_IDX_CW_LO 6'h1b
`define PSCR_IDX_CW_HI 6'h1c
`define PSCR_IDX_BW 6'h25
`define PSCR_IDX_CAP 6'h26
`define PSCR_IDX_PG 6'h27
`define PSCR_IDX_OV 6'h28
`define PSCR_IDX_IRQ_STAT 6'h30
`define PSCR_IDX_IRQ_MASK 6'h31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSCR_RST_BYTE 8'h00
`define PSCR_RST_IRQ 16'h0000
`define PSCR_CAP_VALUE 8'hdf

// ----------------------------------------------------------------
// bandwidth register fields
// ----------------------------------------------------------------
`define PSCR_BW1_HI 3
`define PSCR_BW1_LO 2
`define PSCR_BW2_HI 1
`define PSCR_BW2_LO 0

// ----------------------------------------------------------------
// fault bit positions, shared by power-good and overvoltage
// ----------------------------------------------------------------
`define PSCR_FLT_FOCUS 7
`define PSCR_FLT_AUX1 6
`define PSCR_FLT_AUX2 5
`define PSCR_FLT_CONV1 3
`define PSCR_FLT_CONV2 2

// ----------------------------------------------------------------
// colour wheel scale: one code step in nanovolts, full scale in mV
// ----------------------------------------------------------------
`define PSCR_CW_STEP_NV 76294
`define PSCR_CW_FULL_MV 5000

// ----------------------------------------------------------------
// bus widths and byte lanes
// ----------------------------------------------------------------
`define PSCR_IRQ_W 16
`define PSCR_LANE0 0
`define PSCR_LANE1 1
`define PSCR_ZERO32 32'h0000_0000

`endif

// File: hw/pscr_wb_slave.v
`include "pscr_defines.vh"

// classic wishbone handshake: one wait state, ack for one cycle
module pscr_wb_slave (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // wishbone request
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    // decoded request
    output wire take_out,
    output wire wr_take_out,
    output wire [`PSCR_IDX_W-1:0] idx_out,
    output wire ack_out
);

    reg ack_r; // answer flag, one cycle

    // request taken once; ack_r blocks a second take of same cycle
    assign take_out = wb_cyc_in & wb_stb_in & ~ack_r;
    assign wr_take_out = take_out & wb_we_in;
    // byte address down to word index
    assign idx_out = wb_adr_in[7:2];
    assign ack_out = ack_r;

    // ack follows the take by one edge, drops the cycle after
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take_out;
        end
    end

endmodule // pscr_wb_slave

// File: hw/pscr_irq_bank.v
`include "pscr_defines.vh"

// sticky event bits, write-one-to-clear, masked level interrupt
module pscr_irq_bank (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // events and control
    input wire [`PSCR_IRQ_W-1:0] event_in,
    input wire [`PSCR_IRQ_W-1:0] clear_in,
    input wire [`PSCR_IRQ_W-1:0] mask_in,
    // state
    output wire [`PSCR_IRQ_W-1:0] status_out,
    output wire irq_out
);

    reg [`PSCR_IRQ_W-1:0] status_r; // sticky event bits
    reg irq_r; // registered interrupt level

    assign status_out = status_r;
    assign irq_out = irq_r;

    // set beats clear so an event in the clearing cycle survives
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_r <= `PSCR_RST_IRQ;
        end else begin
            status_r <= (status_r & ~clear_in) | event_in;
        end
    end

    // level output, one cycle behind the status bits
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_in);
        end
    end

endmodule // pscr_irq_bank

// File: hw/pscr_regs.v
`include "pscr_defines.vh"

// ----------------------------------------------------------------
// power controller status and configuration registers
// ----------------------------------------------------------------
module pscr_regs (
    // clock and reset
    input wire ref_clk_in,
    input wire rstn_in,
    // wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output wire [31:0] wb_dat_out,
    output wire wb_ack_out,
    // power-good failure levels from the converters
    input wire focus_buck_pgood_fail_in,
    input wire aux_buck1_pgood_fail_in,
    input wire aux_buck2_pgood_fail_in,
    input wire light_conv1_pgood_fail_in,
    input wire light_conv2_pgood_fail_in,
    // overvoltage failure levels from the converters
    input wire focus_buck_overvolt_in,
    input wire aux_buck1_overvolt_in,
    input wire aux_buck2_overvolt_in,
    input wire light_conv1_overvolt_in,
    input wire light_conv2_overvolt_in,
    // settings to the analogue side
    output wire [15:0] color_wheel_level_out,
    output wire [1:0] light_loop_bw_conv1_out,
    output wire [1:0] light_loop_bw_conv2_out,
    // interrupt
    output wire irq_out
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    wire take; // request accepted this cycle
    wire wr_take; // write accepted this cycle
    wire [`PSCR_IDX_W-1:0] idx; // word index of the request
    wire [`PSCR_IRQ_W-1:0] irq_status; // sticky event bits
    wire [`PSCR_IRQ_W-1:0] irq_events; // new faults this cycle
    wire lane0_wr; // write hits byte lane 0
    wire lane1_wr; // write hits byte lane 1

    reg [7:0] color_wheel_level_low_r; // low byte of wheel code
    reg [7:0] color_wheel_level_high_r; // high byte of wheel code
    reg [7:0] light_loop_bandwidth_r; // bandwidth select byte
    reg [7:0] rail_power_good_faults_r; // live power-good faults
    reg [7:0] rail_overvoltage_faults_r; // live overvoltage faults
    reg [7:0] pg_prev_r; // power-good faults, one cycle back
    reg [7:0] ov_prev_r; // overvoltage faults, one cycle back
    reg [`PSCR_IRQ_W-1:0] irq_mask_r; // interrupt enables
    reg [31:0] rd_dat_r; // read data held for the master
    reg [7:0] pg_nxt; // next power-good image
    reg [7:0] ov_nxt; // next overvoltage image
    reg [31:0] rd_nxt; // read mux result
    reg [`PSCR_IRQ_W-1:0] irq_clear; // write-one-to-clear vector

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    pscr_wb_slave u_wb (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in),
        .take_out(take),
        .wr_take_out(wr_take),
        .idx_out(idx),
        .ack_out(wb_ack_out)
    );

    // registers but the interrupt pair are one byte wide; lane 0 carries all of them
    assign lane0_wr = wr_take & wb_sel_in[`PSCR_LANE0];
    // the interrupt registers also use lane 1
    assign lane1_wr = wr_take & wb_sel_in[`PSCR_LANE1];

    // ----------------------------------------------------------------
    // colour wheel level
    // ----------------------------------------------------------------
    // two bytes written separately; software should write low then
    // high, since the analogue side sees each byte as it lands
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            color_wheel_level_low_r <= `PSCR_RST_BYTE;
            color_wheel_level_high_r <= `PSCR_RST_BYTE;
        end else begin
            // low byte store
            if (lane0_wr && idx == `PSCR_IDX_CW_LO) begin
                color_wheel_level_low_r <= wb_dat_in[7:0];
            end
            // high byte store
            if (lane0_wr && idx == `PSCR_IDX_CW_HI) begin
                color_wheel_level_high_r <= wb_dat_in[7:0];
            end
        end
    end

    // code times the step gives nanovolts, 0xffff lands at 4999.93 mV, just below full scale
    assign color_wheel_level_out = {color_wheel_level_high_r,
                                    color_wheel_level_low_r};

    // ----------------------------------------------------------------
    // converter bandwidth boost
    // ----------------------------------------------------------------
    // reserved upper nibble is never stored, so it reads back zero
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            light_loop_bandwidth_r <= `PSCR_RST_BYTE;
        end else if (lane0_wr && idx == `PSCR_IDX_BW) begin
            light_loop_bandwidth_r <= {4'h0,
                wb_dat_in[`PSCR_BW1_HI:`PSCR_BW2_LO]};
        end
    end

    // codes 0..3 give 0, 1.9, 4.7 and 9.3 db of extra loop gain
    assign light_loop_bw_conv1_out =
        light_loop_bandwidth_r[`PSCR_BW1_HI:`PSCR_BW1_LO];
    assign light_loop_bw_conv2_out =
        light_loop_bandwidth_r[`PSCR_BW2_HI:`PSCR_BW2_LO];

    // ----------------------------------------------------------------
    // fault images
    // ----------------------------------------------------------------
    // build each status byte from the live fault levels; reserved
    // positions are simply never set
    always @* begin
        pg_nxt = `PSCR_RST_BYTE;
        pg_nxt[`PSCR_FLT_FOCUS] = focus_buck_pgood_fail_in;
        pg_nxt[`PSCR_FLT_AUX1] = aux_buck1_pgood_fail_in;
        pg_nxt[`PSCR_FLT_AUX2] = aux_buck2_pgood_fail_in;
        pg_nxt[`PSCR_FLT_CONV1] = light_conv1_pgood_fail_in;
        pg_nxt[`PSCR_FLT_CONV2] = light_conv2_pgood_fail_in;
        ov_nxt = `PSCR_RST_BYTE;
        ov_nxt[`PSCR_FLT_FOCUS] = focus_buck_overvolt_in;
        ov_nxt[`PSCR_FLT_AUX1] = aux_buck1_overvolt_in;
        ov_nxt[`PSCR_FLT_AUX2] = aux_buck2_overvolt_in;
        ov_nxt[`PSCR_FLT_CONV1] = light_conv1_overvolt_in;
        ov_nxt[`PSCR_FLT_CONV2] = light_conv2_overvolt_in;
    end

    // status follows the fault level; no bus write reaches it, and
    // nothing here drives a shutdown path, faults are report-only
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rail_power_good_faults_r <= `PSCR_RST_BYTE;
            rail_overvoltage_faults_r <= `PSCR_RST_BYTE;
            pg_prev_r <= `PSCR_RST_BYTE;
            ov_prev_r <= `PSCR_RST_BYTE;
        end else begin
            rail_power_good_faults_r <= pg_nxt;
            rail_overvoltage_faults_r <= ov_nxt;
            pg_prev_r <= rail_power_good_faults_r;
            ov_prev_r <= rail_overvoltage_faults_r;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    // a fault's rising edge is the event; a fault that stays up is
    // still visible in the live status but raises no second event
    assign irq_events = {rail_overvoltage_faults_r & ~ov_prev_r,
                         rail_power_good_faults_r & ~pg_prev_r};

    // write-one-to-clear per byte lane of the status word
    always @* begin
        irq_clear = `PSCR_RST_IRQ;
        if (idx == `PSCR_IDX_IRQ_STAT) begin
            if (lane0_wr) begin
                irq_clear[7:0] = wb_dat_in[7:0];
            end
            if (lane1_wr) begin
                irq_clear[15:8] = wb_dat_in[15:8];
            end
        end
    end

    // mask register, same layout as status
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_mask_r <= `PSCR_RST_IRQ;
        end else if (idx == `PSCR_IDX_IRQ_MASK) begin
            // low byte: power-good events
            if (lane0_wr) begin
                irq_mask_r[7:0] <= wb_dat_in[7:0];
            end
            // high byte: overvoltage events
            if (lane1_wr) begin
                irq_mask_r[15:8] <= wb_dat_in[15:8];
            end
        end
    end

    pscr_irq_bank u_irq (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .event_in(irq_events),
        .clear_in(irq_clear),
        .mask_in(irq_mask_r),
        .status_out(irq_status),
        .irq_out(irq_out)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped words read zero and are still acknowledged, so a
    // stray access never hangs the bus
    always @* begin
        rd_nxt = `PSCR_ZERO32;
        case (idx)
            `PSCR_IDX_CW_LO: begin
                rd_nxt[7:0] = color_wheel_level_low_r;
            end
            `PSCR_IDX_CW_HI: begin
                rd_nxt[7:0] = color_wheel_level_high_r;
            end
            `PSCR_IDX_BW: begin
                rd_nxt[7:0] = light_loop_bandwidth_r;
            end
            `PSCR_IDX_CAP: begin
                // fixed options: lamp auto-off, external switch, wheel,
                // both ldos from nonvolatile setup, both mirror bucks
                rd_nxt[7:0] = `PSCR_CAP_VALUE;
            end
            `PSCR_IDX_PG: begin
                rd_nxt[7:0] = rail_power_good_faults_r;
            end
            `PSCR_IDX_OV: begin
                rd_nxt[7:0] = rail_overvoltage_faults_r;
            end
            `PSCR_IDX_IRQ_STAT: begin
                rd_nxt[15:0] = irq_status;
            end
            `PSCR_IDX_IRQ_MASK: begin
                rd_nxt[15:0] = irq_mask_r;
            end
            default: begin
                rd_nxt = `PSCR_ZERO32;
            end
        endcase
    end

    // data captured at the take edge, stands with ack and after it
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_dat_r <= `PSCR_ZERO32;
        end else if (take && !wb_we_in) begin
            rd_dat_r <= rd_nxt;
        end
    end

    assign wb_dat_out = rd_dat_r;

endmodule // pscr_regs

// File: tb/pscr_regs_sva.sv
// ----------------------------------------------------------------
// port-level checker for the status and configuration registers
// ----------------------------------------------------------------
module pscr_regs_sva (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // wishbone side
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    // settings
    input wire logic [15:0] color_wheel_level_out,
    input wire logic [1:0] light_loop_bw_conv1_out,
    input wire logic [1:0] light_loop_bw_conv2_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // completed read, and completed write with lane 0 enabled
    wire rd = wb_ack_out && !wb_we_in;
    wire wr = wb_ack_out && wb_we_in && wb_sel_in[0];
    // writes that may legally move a setting
    wire wr_cfg = wr && (wb_adr_in == 8'h6c || wb_adr_in == 8'h70 ||
        wb_adr_in == 8'h94);

    chk_ack_timing: assert property (
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack missing one cycle after a request");
    chk_ack_pulse: assert property (
        wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    chk_wheel_high: assert property (
        wr && wb_adr_in == 8'h70 |-> color_wheel_level_out[15:8] ==
        wb_dat_in[7:0])
        else $error("wheel high byte not stored");
    chk_wheel_low: assert property (
        wr && wb_adr_in == 8'h6c |-> color_wheel_level_out[7:0] ==
        wb_dat_in[7:0])
        else $error("wheel low byte not stored");
    chk_bw_map: assert property (
        wr && wb_adr_in == 8'h94 |-> light_loop_bw_conv1_out ==
        wb_dat_in[3:2] && light_loop_bw_conv2_out == wb_dat_in[1:0])
        else $error("bandwidth fields misplaced");
    chk_cfg_hold: assert property (
        !wr_cfg |-> $stable({color_wheel_level_out,
        light_loop_bw_conv1_out, light_loop_bw_conv2_out}))
        else $error("setting moved without a write");
    chk_cap_read: assert property (
        rd && wb_adr_in == 8'h98 |-> wb_dat_out[7:0] == 8'hdf)
        else $error("capability value wrong");
    chk_pg_rsvd: assert property (
        rd && wb_adr_in == 8'h9c |-> wb_dat_out[1:0] == 2'h0)
        else $error("power-good reserved bits set");
    chk_ov_rsvd: assert property (
        rd && wb_adr_in == 8'ha0 |-> wb_dat_out[4] == 1'b0 &&
        wb_dat_out[1:0] == 2'h0)
        else $error("overvoltage reserved bits set");
endmodule // pscr_regs_sva

bind pscr_regs pscr_regs_sva u_sva (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .color_wheel_level_out(color_wheel_level_out),
    .light_loop_bw_conv1_out(light_loop_bw_conv1_out),
    .light_loop_bw_conv2_out(light_loop_bw_conv2_out)
);

// File: tb/pscr_regs_test.sv
module pscr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // stimulus, observed outputs and reference model state
    // ----------------------------------------------------------------
    logic clk, rstn, cyc, stb, we;
    logic [7:0] adr, a, x;
    logic [3:0] sel;
    logic [31:0] wdat, q, d, seed;
    logic [9:0] flt, old; // [9:5] overvoltage, [4:0] power-good
    wire [31:0] rdat;
    wire ack, irq;
    wire [15:0] cw;
    wire [1:0] bw1, bw2;
    logic [7:0] m_lo, m_hi;
    logic [3:0] m_bw;
    logic [15:0] m_st, m_msk;
    int fail_count, compares, cycles;
    logic [7:0] ra [8] = '{8'h6c, 8'h70, 8'h94, 8'h98, 8'h9c, 8'ha0,
        8'hc0, 8'hc4};
    logic [7:0] ro [4] = '{8'h98, 8'h9c, 8'ha0, 8'h00};

    pscr_regs DUT (
        .ref_clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .focus_buck_pgood_fail_in(flt[4]),
        .aux_buck1_pgood_fail_in(flt[3]), .aux_buck2_pgood_fail_in(flt[2]),
        .light_conv1_pgood_fail_in(flt[1]),
        .light_conv2_pgood_fail_in(flt[0]),
        .focus_buck_overvolt_in(flt[9]), .aux_buck1_overvolt_in(flt[8]),
        .aux_buck2_overvolt_in(flt[7]), .light_conv1_overvolt_in(flt[6]),
        .light_conv2_overvolt_in(flt[5]), .color_wheel_level_out(cw),
        .light_loop_bw_conv1_out(bw1), .light_loop_bw_conv2_out(bw2),
        .irq_out(irq)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // xorshift keeps the run repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // five fault levels to their register byte
    function automatic logic [7:0] img(input logic [4:0] p);
        return {p[4], p[3], p[2], 1'b0, p[1], p[0], 2'b00};
    endfunction

    task automatic chk(input logic [31:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    // one classic cycle; waits for ack however long it takes, only the
    // bench timeout ends a hang; the latency seen is then checked
    task automatic wb(input logic [7:0] ad, input logic w,
        input logic [31:0] dt, input logic [3:0] s, output logic [31:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= dt;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        r = rdat;
        // request edge plus one wait state: ack seen at the second edge
        chk(n, 2, "ack latency");
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // a few hundred cycles are expected; far above that is a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            chk(0, 1, "timeout");
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn, cyc, stb, we, adr, sel, wdat, flt, old} = '0;
        {m_lo, m_hi, m_bw, m_st} = '0;
        seed = 32'd34888;
        repeat (5) @(posedge clk);
        chk({cw, bw1, bw2, irq}, 0, "reset outputs");
        rstn <= 1'b1;
        // reset values of every mapped register
        foreach (ra[i]) begin
            wb(ra[i], 1'b0, 0, 4'h1, q);
            chk(q, i == 3 ? 32'hdf : 0, "reset value");
        end
        // random config writes, lane 0 sometimes off
        repeat (14) begin
            a = ra[rnd() % 3];
            d = rnd();
            wb(a, 1'b1, d, d[11:8], q);
            if (d[8] && a == 8'h6c) m_lo = d[7:0];
            else if (d[8] && a == 8'h70) m_hi = d[7:0];
            else if (d[8]) m_bw = d[3:0];
            wb(a, 1'b0, 0, 4'h1, q);
            x = a == 8'h6c ? m_lo : a == 8'h70 ? m_hi : m_bw;
            chk(q, x, "readback");
            chk({cw, bw1, bw2}, {m_hi, m_lo, m_bw}, "settings");
        end
        // writes to read-only and unmapped places change nothing
        foreach (ro[i]) begin
            wb(ro[i], 1'b1, 32'hffff_ffff, 4'hf, q);
            wb(ro[i], 1'b0, 0, 4'h1, q);
            chk(q, ro[i] == 8'h98 ? 32'hdf : 0, "read-only");
        end
        // faults: live images, sticky events, masked interrupt
        d = rnd();
        m_msk = d[15:0];
        wb(8'hc4, 1'b1, d, 4'h3, q);
        repeat (12) begin
            d = rnd();
            flt <= d[9:0];
            repeat (4) @(posedge clk);
            m_st |= {img(d[9:5] & ~old[9:5]), img(d[4:0] & ~old[4:0])};
            old = d[9:0];
            wb(8'h9c, 1'b0, 0, 4'h1, q);
            chk(q, img(old[4:0]), "power-good");
            wb(8'ha0, 1'b0, 0, 4'h1, q);
            chk(q, img(old[9:5]), "overvoltage");
            wb(8'hc0, 1'b0, 0, 4'h3, q);
            chk(q, m_st, "event status");
            chk(irq, |(m_st & m_msk), "irq level");
            d = rnd();
            wb(8'hc0, 1'b1, d, 4'h3, q);
            m_st &= ~d[15:0];
            repeat (2) @(posedge clk);
            chk(irq, |(m_st & m_msk), "irq after clear");
        end
        stop_test();
    end
endmodule // pscr_regs_test
